// ===== hdl/ctfsm_pkg.sv
// Shared constants and carrier types for the contactless tag command logic.
// Assumes a single core clock; link pins are asynchronous to it.
package ctfsm_pkg;
    localparam logic [7:0] CMD_REQA = 8'h26;
    localparam logic [7:0] CMD_WUPA = 8'h52;
    localparam logic [7:0] CMD_SEL1 = 8'h93;
    localparam logic [7:0] PAR_SELECT = 8'h70;
    localparam logic [7:0] PAR_AC_LO = 8'h20;
    localparam logic [7:0] PAR_AC_HI = 8'h67;
    localparam logic [7:0] CMD_READ = 8'h30;
    localparam logic [7:0] CMD_WRITE = 8'ha2;
    localparam logic [7:0] CMD_HALT = 8'h50;
    localparam logic [7:0] PAR_HALT = 8'h00;
    localparam logic [7:0] CASCADE_TAG = 8'h88;
    localparam logic [7:0] NUM_PAGES = 8'h10;
    localparam logic [3:0] PAGE_LOCK = 4'h2;
    localparam logic [3:0] PAGE_OTP = 4'h3;
    localparam logic [15:0] CRC_INIT = 16'h6363;
    localparam logic [15:0] CRC_POLY = 16'h8408;
    localparam logic [3:0] ACK_CODE = 4'ha;
    localparam logic [3:0] NAK_CODE = 4'h0;
    localparam logic [7:0] MAX_FRAME_BITS = 8'd163;
    localparam logic [7:0] SHORT_FRAME_BITS = 8'd8;
    localparam logic [3:0] RX_BYTES = 4'd9;
    localparam logic [31:0] CTRL_OFS = 32'h0000_0000;
    localparam logic [31:0] STATUS_OFS = 32'h0000_0004;
    localparam logic [31:0] ERRCNT_OFS = 32'h0000_0008;
    localparam logic CTRL_ENABLE_RST = 1'b1;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_READY1 = 3'b001,
        ST_READY2 = 3'b010,
        ST_ACTIVE = 3'b011,
        ST_HALT = 3'b100
    } ctfsm_state_e;

    typedef struct packed {
        logic clk;
        logic data;
        logic frame;
        logic viol;
    } ctfsm_link_s;
endpackage : ctfsm_pkg

// ===== hdl/ctfsm_top.sv
// Command interpreter, frame checker and page memory of a contactless tag.
// Assumes the reader keeps the link clock running while a reply is sent.
//
// Contract
// - Active state performs a sixteen-byte read or a four-byte page write.
// - HALT in Active ends the session and makes Halt the waiting state.
// - Unexpected frame in Active returns the tag to its waiting state.
// - Halt is left only by WUPA; other frames keep it halted silently.
// - Blocks carry a 16-bit CRC; bit count, coding and sequence are checked.
// - Each frame starts with one start bit; each byte has odd parity.
// - Bits go least significant first, lowest address byte first.
// - No frame is longer than 163 bits.
// - Memory is pages of four bytes; erased cells read as zero.
// - Serial and check bytes fill the first nine bytes, write-protected.
// - Check bytes are XOR of cascade tag and serial bytes as defined.
// - Page two lock bits make pages three to fifteen read-only.
// - Low three bits of lock byte zero freeze their lock groups.
// - Writing page two ORs data into lock bytes; bits never clear.
// - Page two bytes zero and one ignore write data.
// - New lock configuration applies only after REQA or WUPA.
// - OTP page starts at zero and each write ORs into it.
// - Pages after OTP form the user area, zero after production.
// - REQA short frame accepted only in Idle, answered with ATQA.
// - WUPA short frame accepted in Idle and Halt, answered with ATQA.
// - Code 0x93 only in Ready1; 0x70 selects, 0x20-0x67 anticollides.
// - Select carries UID part with check byte and CRC, answered by SAK.
// - Correct cascade-one select in Ready1 moves the tag to Ready2.
// - Read of page zero in Ready1 or Ready2 enters Active directly.
// - After HALT, error recovery returns to Halt instead of Idle.
`timescale 1ns/1ns
`default_nettype none
module ctfsm_top import ctfsm_pkg::*; #(
    parameter logic [55:0] UID = 56'h77_6655_4433_2211, // Arbitrary serial number.
    parameter logic [15:0] ATQA = 16'h0101, // Arbitrary value.
    parameter logic [7:0] SAK = 8'h24 // Arbitrary value.
) (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire ctfsm_link_s link_in,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic tx_data,
    output logic tx_frame
);
    typedef struct packed {
        ctfsm_link_s sy1;
        ctfsm_link_s sy2;
        logic clk_d;
        ctfsm_state_e st;
        logic halt_wait;
        logic [15:0] lock_act;
        logic [15:0][3:0][7:0] mem;
        logic rx_on;
        logic [7:0] rx_bits;
        logic [3:0] rx_ph;
        logic [7:0] rx_cur;
        logic [8:0][7:0] rx_buf;
        logic [3:0] rx_n;
        logic rx_perr;
        logic rx_ovf;
        logic rx_viol;
        logic [17:0][7:0] tx_buf;
        logic [4:0] tx_n;
        logic [4:0] tx_i;
        logic [3:0] tx_b;
        logic tx_busy;
        logic tx_start;
        logic tx_short;
        logic tx_data;
        logic tx_frame;
        logic [7:0] tx_cnt;
        logic enable;
        logic [7:0] errcnt;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } ctfsm_st_s;

    ctfsm_st_s s;
    ctfsm_st_s n;

    function automatic logic [15:0] ctfsm_crc(input logic [17:0][7:0] b, input logic [4:0] cnt);
        logic [15:0] c;
        c = CRC_INIT;
        for (int i = 0; i < 18; i++) begin
            for (int k = 0; k < 8; k++) begin
                if (5'(i) < cnt) begin
                    c = (c[0] ^ b[i][k]) ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
                end
            end
        end
        return c;
    endfunction : ctfsm_crc

    function automatic logic [15:0][3:0][7:0] ctfsm_init_mem(input logic [55:0] u);
        logic [15:0][3:0][7:0] m;
        m = '0;
        m[0] = {CASCADE_TAG ^ u[7:0] ^ u[15:8] ^ u[23:16], u[23:0]};
        m[1] = u[55:24];
        m[2][0] = u[31:24] ^ u[39:32] ^ u[47:40] ^ u[55:48];
        return m;
    endfunction : ctfsm_init_mem

    logic rise;
    logic fe;
    logic short_f;
    logic full_f;
    logic crc_ok;
    logic is_reqa;
    logic is_wupa;
    logic is_ac;
    logic is_sel;
    logic is_rd;
    logic is_wr;
    logic is_halt;
    logic pg_ok;
    logic wr_lock;
    logic wake;
    logic acc;
    logic [3:0] pg;
    logic [7:0] c0;
    logic [7:0] c1;
    logic [3:0][7:0] wdat;
    ctfsm_state_e wait_st;

    assign rise = s.sy2.clk & ~s.clk_d;
    assign fe = s.rx_on & ~s.sy2.frame;
    assign c0 = s.rx_buf[0];
    assign c1 = s.rx_buf[1];
    assign pg = c1[3:0];
    assign wdat = s.rx_buf[5:2];
    assign short_f = s.rx_bits == SHORT_FRAME_BITS && s.rx_n == 4'd0 && !s.rx_viol;
    assign full_f = s.rx_n != 4'd0 && s.rx_ph == 4'd0 && !s.rx_perr && !s.rx_viol
        && !s.rx_ovf;
    assign crc_ok = ctfsm_crc({72'h0, s.rx_buf}, {1'b0, s.rx_n}) == 16'h0000;
    assign is_reqa = short_f && s.rx_cur[6:0] == CMD_REQA[6:0];
    assign is_wupa = short_f && s.rx_cur[6:0] == CMD_WUPA[6:0];
    assign is_ac = full_f && s.rx_n == 4'd2 && c0 == CMD_SEL1
        && c1 >= PAR_AC_LO && c1 <= PAR_AC_HI;
    assign is_sel = full_f && s.rx_n == RX_BYTES && c0 == CMD_SEL1 && c1 == PAR_SELECT
        && crc_ok && s.rx_buf[2] == CASCADE_TAG && s.rx_buf[6:3] == s.mem[0];
    assign is_rd = full_f && s.rx_n == 4'd4 && c0 == CMD_READ && crc_ok;
    assign is_wr = full_f && s.rx_n == 4'd8 && c0 == CMD_WRITE && crc_ok;
    assign is_halt = full_f && s.rx_n == 4'd4 && c0 == CMD_HALT && c1 == PAR_HALT && crc_ok;
    assign pg_ok = c1 < NUM_PAGES;
    assign wr_lock = pg < PAGE_LOCK || (pg >= PAGE_OTP && s.lock_act[pg]);
    assign wait_st = s.halt_wait ? ST_HALT : ST_IDLE;
    assign wake = (s.st == ST_IDLE && (is_reqa || is_wupa))
        || (s.st == ST_HALT && is_wupa);
    assign acc = wake
        || (s.st == ST_READY1 && (is_ac || is_sel || (is_rd && c1 == 8'h00)))
        || (s.st == ST_READY2 && is_rd && c1 == 8'h00)
        || (s.st == ST_ACTIVE && ((is_rd && pg_ok) || is_halt || (is_wr && pg_ok && !wr_lock)));

    always_comb begin
        logic go;
        logic add_crc;
        logic [4:0] dn;
        logic [15:0] c;
        logic [15:0] m;
        go = 1'b0;
        add_crc = 1'b0;
        dn = 5'd0;
        c = 16'h0000;
        m = 16'hffff;
        n = s;
        n.sy1 = link_in;
        n.sy2 = s.sy1;
        n.clk_d = s.sy2.clk;
        // Register bus: one wait state, writes land on the completing edge.
        n.pready = psel && penable && !s.pready;
        if (psel && penable && !s.pready) begin
            n.pslverr = 1'b0;
            n.prdata = 32'h0000_0000;
            case (paddr)
                CTRL_OFS: n.prdata = {31'h0, s.enable};
                STATUS_OFS: begin
                    n.prdata = {s.lock_act, 11'h0, s.tx_busy, s.halt_wait, s.st};
                    n.pslverr = pwrite;
                end
                ERRCNT_OFS: n.prdata = {24'h0, s.errcnt};
                default: n.pslverr = 1'b1;
            endcase
        end
        if (psel && penable && s.pready && pwrite && !s.pslverr) begin
            if (paddr == CTRL_OFS) begin
                n.enable = pwdata[0];
            end
            if (paddr == ERRCNT_OFS) begin
                n.errcnt = 8'h00;
            end
        end
        // Receiver: start bit, then eight data bits and a parity bit per byte.
        if (!s.rx_on) begin
            if (s.sy2.frame && !s.tx_busy && s.enable) begin
                n.rx_on = 1'b1;
                n.rx_bits = 8'd0;
                n.rx_ph = 4'd0;
                n.rx_n = 4'd0;
                n.rx_perr = 1'b0;
                n.rx_ovf = 1'b0;
                n.rx_viol = 1'b0;
            end
        end else if (rise && s.sy2.frame) begin
            if (s.rx_bits != 8'hff) begin
                n.rx_bits = s.rx_bits + 8'd1;
            end
            if (s.rx_bits >= MAX_FRAME_BITS) begin
                n.rx_ovf = 1'b1;
            end
            if (s.sy2.viol) begin
                n.rx_viol = 1'b1;
            end
            if (s.rx_bits == 8'd0) begin
                n.rx_viol = s.sy2.viol || !s.sy2.data;
            end else if (s.rx_ph == 4'd8) begin
                if (s.sy2.data != ~^s.rx_cur) begin
                    n.rx_perr = 1'b1;
                end
                if (s.rx_n < RX_BYTES) begin
                    n.rx_buf[s.rx_n] = s.rx_cur;
                    n.rx_n = s.rx_n + 4'd1;
                end else begin
                    n.rx_ovf = 1'b1;
                end
                n.rx_ph = 4'd0;
            end else begin
                n.rx_cur[s.rx_ph[2:0]] = s.sy2.data;
                n.rx_ph = s.rx_ph + 4'd1;
            end
        end
        // Frame end: decide on the command for the current state.
        if (fe) begin
            n.rx_on = 1'b0;
            if (!acc && n.errcnt != 8'hff) begin
                n.errcnt = n.errcnt + 8'd1;
            end
            n.tx_short = 1'b0;
            case (s.st)
                ST_IDLE, ST_HALT: begin
                    if (wake) begin
                        n.st = ST_READY1;
                        n.lock_act = s.mem[2][3:2];
                        n.tx_buf[1:0] = ATQA;
                        dn = 5'd2;
                        go = 1'b1;
                    end
                end
                ST_READY1, ST_READY2: begin
                    if (s.st == ST_READY1 && is_ac) begin
                        n.tx_buf[4:0] = {s.mem[0], CASCADE_TAG};
                        dn = 5'd5;
                        go = 1'b1;
                    end else if (s.st == ST_READY1 && is_sel) begin
                        n.st = ST_READY2;
                        n.tx_buf[0] = SAK;
                        dn = 5'd1;
                        add_crc = 1'b1;
                        go = 1'b1;
                    end else if (is_rd && c1 == 8'h00) begin
                        n.st = ST_ACTIVE;
                    end else begin
                        n.st = wait_st;
                    end
                end
                ST_ACTIVE: begin
                    if (is_halt) begin
                        n.st = ST_HALT;
                        n.halt_wait = 1'b1;
                    end else if (is_wr && pg_ok && !wr_lock) begin
                        if (pg == PAGE_LOCK) begin
                            m[3] = !s.lock_act[0];
                            m[9:4] = {6{!s.lock_act[1]}};
                            m[15:10] = {6{!s.lock_act[2]}};
                            n.mem[2][3:2] = s.mem[2][3:2] | (wdat[3:2] & m);
                        end else if (pg == PAGE_OTP) begin
                            n.mem[pg] = s.mem[pg] | wdat;
                        end else begin
                            n.mem[pg] = wdat;
                        end
                        n.tx_buf[0] = {4'h0, ACK_CODE};
                        n.tx_short = 1'b1;
                        dn = 5'd1;
                        go = 1'b1;
                    end else if (is_wr || (is_rd && !pg_ok)) begin
                        n.st = wait_st;
                        n.tx_buf[0] = {4'h0, NAK_CODE};
                        n.tx_short = 1'b1;
                        dn = 5'd1;
                        go = 1'b1;
                    end else if (!is_rd) begin
                        n.st = wait_st;
                    end
                end
                default: n.st = ST_IDLE;
            endcase
            if (is_rd && acc) begin
                for (int k = 0; k < 16; k++) begin
                    n.tx_buf[k] = s.mem[4'(int'(pg) + k / 4)][k % 4];
                end
                dn = 5'd16;
                add_crc = 1'b1;
                go = 1'b1;
            end
            if (add_crc) begin
                c = ctfsm_crc(n.tx_buf, dn);
                n.tx_buf[dn] = c[7:0];
                n.tx_buf[5'(dn + 5'd1)] = c[15:8];
                dn = 5'(dn + 5'd2);
            end
            if (go) begin
                n.tx_busy = 1'b1;
                n.tx_start = 1'b1;
                n.tx_n = dn;
                n.tx_i = 5'd0;
                n.tx_b = 4'd0;
            end
        end
        // Transmitter: one bit per rising link clock edge.
        if (rise && s.tx_busy) begin
            if (s.tx_start) begin
                n.tx_start = 1'b0;
                n.tx_frame = 1'b1;
                n.tx_data = 1'b1;
                n.tx_cnt = 8'd1;
            end else if (s.tx_i == s.tx_n) begin
                n.tx_busy = 1'b0;
                n.tx_frame = 1'b0;
                n.tx_data = 1'b0;
            end else begin
                n.tx_cnt = s.tx_cnt + 8'd1;
                n.tx_data = (s.tx_b == 4'd8) ? ~^s.tx_buf[s.tx_i]
                    : s.tx_buf[s.tx_i][s.tx_b[2:0]];
                if ((s.tx_short && s.tx_b == 4'd3) || s.tx_b == 4'd8) begin
                    n.tx_b = 4'd0;
                    n.tx_i = s.tx_i + 5'd1;
                end else begin
                    n.tx_b = s.tx_b + 4'd1;
                end
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            s <= '0;
            s.mem <= ctfsm_init_mem(UID);
            s.enable <= CTRL_ENABLE_RST;
        end else begin
            s <= n;
        end
    end

    assign prdata = s.prdata;
    assign pready = s.pready;
    assign pslverr = s.pslverr;
    assign tx_data = s.tx_data;
    assign tx_frame = s.tx_frame;

    halt_stay_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        s.st == ST_HALT && !(fe && is_wupa) |=> s.st == ST_HALT)
        else $error("halt left without wake-up");
    active_err_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        fe && s.st == ST_ACTIVE && !acc |=> s.st == (s.halt_wait ? ST_HALT : ST_IDLE))
        else $error("bad frame in active did not return to waiting state");
    lock_or_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        (s.mem[2][3:2] & $past(s.mem[2][3:2])) == $past(s.mem[2][3:2]))
        else $error("lock bit cleared");
    otp_or_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        (s.mem[3] & $past(s.mem[3])) == $past(s.mem[3]))
        else $error("otp bit cleared");
    uid_fixed_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        $stable(s.mem[1:0]) && $stable(s.mem[2][1:0]))
        else $error("serial bytes changed");
    lock_apply_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        $changed(s.lock_act) |-> $past(fe && wake))
        else $error("lock configuration applied without wake-up");
    frame_len_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        s.tx_cnt <= MAX_FRAME_BITS)
        else $error("reply longer than maximum frame");
    start_bit_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        $rose(tx_frame) |-> tx_data ##1 tx_frame)
        else $error("reply without start bit");
    reqa_idle_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        fe && is_reqa && s.st != ST_IDLE |=> s.st != ST_READY1 || $past(s.st) == ST_READY1)
        else $error("reqa accepted outside idle");
    sel_ready2_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        fe && s.st == ST_READY1 && is_sel |=> s.st == ST_READY2 && s.tx_busy)
        else $error("select did not reach ready2");
endmodule : ctfsm_top
`default_nettype wire

// ===== verif/contactless_tag_command_fsm_bench.sv
// Bench: reader frames and APB accesses with expected replies and status.
// Assumes the reader model and the design top in the same compile.
`timescale 1ns/1ns
`default_nettype none
module contactless_tag_command_fsm_bench import ctfsm_pkg::*; ;
    typedef logic ctfsm_bits_t[$];
    typedef logic [7:0] ctfsm_bytes_t[$];
    logic core_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] paddr = 32'h0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rv;
    logic pready, pslverr, tx_data, tx_frame, ev;
    ctfsm_link_s link;
    int errors = 0;
    int checks = 0;
    int cyc = 0;
    logic [7:0] b0, b1;
    ctfsm_bytes_t p01, z12, otp;
    ctfsm_bits_t q, none, ack, nak, atqa, rz;
    ctfsm_top #(.UID(56'h7a_6b5c_4d3e_2f19)) i_dut (
        .core_clk(core_clk), .sys_rst(sys_rst), .link_in(link), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .tx_data(tx_data),
        .tx_frame(tx_frame));
    ctfsm_reader_model i_reader (.core_clk(core_clk), .tx_data(tx_data),
        .tx_frame(tx_frame), .link_out(link));
    initial begin
        forever #2 core_clk = ~core_clk;
    end
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic close_out();
        if (errors == 0 && checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : close_out
    task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do begin
            @(posedge core_clk);
        end while (pready !== 1'b1);
        rv = prdata;
        ev = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge core_clk);
    endtask : apb
    task automatic rd(input string what, input logic [31:0] a, input logic [31:0] x, input logic e);
        apb(1'b0, a, 32'h0);
        check(what, rv, x);
        check(what, {31'h0, ev}, {31'h0, e});
    endtask : rd
    function automatic ctfsm_bits_t mks(input logic [7:0] v, input int n);
        ctfsm_bits_t t;
        t.push_back(1'b1);
        for (int k = 0; k < n; k++) begin
            t.push_back(v[k]);
        end
        return t;
    endfunction : mks
    function automatic ctfsm_bits_t mkf(input ctfsm_bytes_t by, input bit crc);
        logic [15:0] c;
        ctfsm_bits_t t;
        c = CRC_INIT;
        foreach (by[i]) begin
            for (int k = 0; k < 8; k++) begin
                c = (c >> 1) ^ ((c[0] ^ by[i][k]) ? CRC_POLY : 16'h0);
            end
        end
        if (crc) begin
            by.push_back(c[7:0]);
            by.push_back(c[15:8]);
        end
        t.push_back(1'b1);
        foreach (by[i]) begin
            for (int k = 0; k < 8; k++) begin
                t.push_back(by[i][k]);
            end
            t.push_back(~^by[i]);
        end
        return t;
    endfunction : mkf
    task automatic run(input string what, input ctfsm_bits_t tx, input ctfsm_bits_t x,
            input logic v = 1'b0);
        logic ok;
        i_reader.xfer(tx, v);
        ok = i_reader.rsp.size() == x.size();
        foreach (x[i]) begin
            if (ok && i_reader.rsp[i] !== x[i]) begin
                ok = 1'b0;
            end
        end
        check(what, {31'h0, ok}, 32'h1);
    endtask : run
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            errors++;
            close_out();
        end
    end
    initial begin
        b0 = CASCADE_TAG ^ 8'h19 ^ 8'h2f ^ 8'h3e;
        b1 = 8'h4d ^ 8'h5c ^ 8'h6b ^ 8'h7a;
        p01 = {8'h19, 8'h2f, 8'h3e, b0, 8'h4d, 8'h5c, 8'h6b, 8'h7a};
        repeat (12) z12.push_back(8'h00);
        otp = {8'hff, 8'hfc, 8'h3d, 8'h87};
        ack = mks({4'h0, ACK_CODE}, 4);
        nak = mks({4'h0, NAK_CODE}, 4);
        atqa = mkf({8'h01, 8'h01}, 1'b0);
        rz = mkf({CMD_READ, 8'h00}, 1'b1);
        repeat (6) @(posedge core_clk);
        sys_rst <= 1'b0;
        @(posedge core_clk);
        rd("ctrl", CTRL_OFS, 32'h1, 1'b0);
        rd("unmapped", 32'h10, 32'h0, 1'b1);
        apb(1'b1, STATUS_OFS, 32'h3);
        check("status write", {31'h0, ev}, 32'h1);
        run("violation", mks(CMD_REQA, 7), none, 1'b1);
        q = mkf({CMD_SEL1, PAR_AC_LO}, 1'b0);
        q[9] = ~q[9];
        run("parity", q, none);
        rd("idle", STATUS_OFS, 32'h0, 1'b0);
        run("reqa", mks(CMD_REQA, 7), atqa);
        run("anticoll", mkf({CMD_SEL1, PAR_AC_LO}, 1'b0),
            mkf({CASCADE_TAG, p01[0:2], b0}, 1'b0));
        run("select", mkf({CMD_SEL1, PAR_SELECT, CASCADE_TAG, p01[0:2], b0}, 1'b1),
            mkf({8'h24}, 1'b1));
        rd("ready2", STATUS_OFS, 32'h2, 1'b0);
        run("read0", rz, mkf({p01, b1, 8'h00, 8'h00, 8'h00, z12[0:3]}, 1'b1));
        rd("active", STATUS_OFS, 32'h3, 1'b0);
        run("otp1", mkf({CMD_WRITE, 8'h03, 8'hff, 8'hfc, 8'h05, 8'h07}, 1'b1), ack);
        run("otp2", mkf({CMD_WRITE, 8'h03, 8'hff, 8'h00, 8'h39, 8'h80}, 1'b1), ack);
        run("lockw", mkf({CMD_WRITE, 8'h02, 8'hff, 8'hff, 8'h12, 8'h00}, 1'b1), ack);
        run("lockr", mkf({CMD_READ, 8'h02}, 1'b1),
            mkf({b1, 8'h00, 8'h12, 8'h00, otp, z12[0:7]}, 1'b1));
        run("pre", mkf({CMD_WRITE, 8'h04, 8'hde, 8'had, 8'hbe, 8'hef}, 1'b1), ack);
        run("halt", mkf({CMD_HALT, PAR_HALT}, 1'b1), none);
        rd("halted", STATUS_OFS, 32'hc, 1'b0);
        run("reqa halt", mks(CMD_REQA, 7), none);
        run("wupa", mks(CMD_WUPA, 7), atqa);
        rd("locks", STATUS_OFS, 32'h0012_0009, 1'b0);
        run("skip", rz, mkf({p01, b1, 8'h00, 8'h12, 8'h00, otp}, 1'b1));
        run("locked", mkf({CMD_WRITE, 8'h04, 8'h01, 8'h02, 8'h03, 8'h04}, 1'b1), nak);
        rd("wait", STATUS_OFS, 32'h0012_000c, 1'b0);
        run("wupa2", mks(CMD_WUPA, 7), atqa);
        run("read0b", rz, mkf({p01, b1, 8'h00, 8'h12, 8'h00, otp}, 1'b1));
        run("freeze", mkf({CMD_WRITE, 8'h02, 8'h00, 8'h00, 8'h20, 8'h00}, 1'b1), ack);
        run("frozen", mkf({CMD_READ, 8'h02}, 1'b1), mkf({b1, 8'h00, 8'h12, 8'h00, otp,
            8'hde, 8'had, 8'hbe, 8'hef, z12[0:3]}, 1'b1));
        run("user", mkf({CMD_READ, 8'h04}, 1'b1),
            mkf({8'hde, 8'had, 8'hbe, 8'hef, z12}, 1'b1));
        q = mkf({CMD_READ, 8'h04}, 1'b1);
        q[20] = ~q[20];
        q[27] = ~q[27];
        run("crc", q, none);
        rd("crc wait", STATUS_OFS, 32'h0012_000c, 1'b0);
        rd("errcnt count", ERRCNT_OFS, 32'h5, 1'b0);
        apb(1'b1, ERRCNT_OFS, 32'h0);
        rd("errcnt", ERRCNT_OFS, 32'h0, 1'b0);
        apb(1'b1, CTRL_OFS, 32'h0);
        run("disabled", mks(CMD_WUPA, 7), none);
        rd("ctrl0", CTRL_OFS, 32'h0, 1'b0);
        close_out();
    end
endmodule : contactless_tag_command_fsm_bench
`default_nettype wire

// ===== verif/ctfsm_reader_model.sv
// Reader model: sends bit frames on the link pins and records the reply bits.
// Assumes the core clock paces the link clock at 16 core cycles a bit.
`timescale 1ns/1ns
`default_nettype none
module ctfsm_reader_model import ctfsm_pkg::*; (
    input wire logic core_clk,
    input wire logic tx_data,
    input wire logic tx_frame,
    output var ctfsm_link_s link_out
);
    logic rsp[$];
    initial begin
        link_out = '0;
    end
    task automatic tick(input logic c);
        link_out.clk <= c;
        repeat (8) @(posedge core_clk);
    endtask : tick
    // Sends one frame, then keeps the clock running while a reply lasts.
    task automatic xfer(input logic b[$], input logic v);
        bit seen;
        seen = 1'b0;
        rsp = {};
        link_out.frame <= 1'b1;
        tick(1'b0);
        foreach (b[i]) begin
            link_out.data <= b[i];
            link_out.viol <= v && i == 3;
            tick(1'b0);
            tick(1'b1);
        end
        link_out.frame <= 1'b0;
        link_out.data <= ~b[b.size() - 1];
        link_out.viol <= 1'b0;
        tick(1'b0);
        for (int k = 0; k < 200; k++) begin
            tick(1'b1);
            if (tx_frame === 1'b1) begin
                rsp.push_back(tx_data);
                seen = 1'b1;
            end else if (seen || k > 8) begin
                break;
            end
            tick(1'b0);
        end
        tick(1'b0);
    endtask : xfer
endmodule : ctfsm_reader_model
`default_nettype wire
